/* File: common/fwp_pkg.sv */
package fwp_pkg;
   // Bus widths of the flash pins
   localparam int ADDR_W = 20;
   localparam int DATA_W = 16;

   // Command codes written to the command interface
   localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
   localparam logic [7:0] CMD_READ_STATUS = 8'h70;
   localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
   localparam logic [7:0] CMD_PROGRAM_SETUP = 8'h40;
   localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
   localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hd0;

   // Status register bit positions
   localparam int SR_READY_BIT = 7;
   localparam int SR_ERASE_ERR_BIT = 5;
   localparam int SR_PROG_ERR_BIT = 4;
   localparam int SR_SUPPLY_LOW_BIT = 3;

   // Host operation codes
   localparam logic [1:0] OP_READ = 2'h0;
   localparam logic [1:0] OP_PROGRAM = 2'h1;
   localparam logic [1:0] OP_ERASE = 2'h2;

   // Pin timing, in ns, and derived cycle counts at 50 MHz
   localparam int CLK_NS = 20;
   localparam int ACCESS_NS = 120;
   localparam int STROBE_NS = 60;
   localparam int RESET_PULSE_NS = 100;
   localparam int RESET_RECOVERY_NS = 600;
   localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
   localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
   localparam int RESET_PULSE_CYC = (RESET_PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam int RESET_RECOVERY_CYC = (RESET_RECOVERY_NS + CLK_NS - 1) / CLK_NS;

   // Poll limit before a busy operation is abandoned
   localparam int POLL_LIMIT = 4000;
   localparam int CNT_W = 12;

   typedef enum logic [3:0] {
      FWP_RESET_HOLD, FWP_RECOVER, FWP_IDLE, FWP_CYCLE, FWP_GAP,
      FWP_POLL, FWP_CLEAR, FWP_RESTORE, FWP_DONE
   } fwp_state_e;
endpackage

/* File: common/fwp_cyc_if.sv */
`timescale 1ns/1ps
// Request and answer between the sequencer and the strobe engine
interface fwp_cyc_if;
   logic start;
   logic write;
   logic [fwp_pkg::ADDR_W-1:0] addr;
   logic [fwp_pkg::DATA_W-1:0] wdata;
   logic done;
   logic [fwp_pkg::DATA_W-1:0] rdata;
   modport seq (output start, output write, output addr, output wdata,
                input done, input rdata);
   modport eng (input start, input write, input addr, input wdata,
                output done, output rdata);
endinterface

/* File: src/fwp_strobe.sv */
`timescale 1ns/1ps
// One bus cycle on the flash pins: write with chip select and write strobe, or read
module fwp_strobe (
   input wire logic clk_i,
   input wire logic rst_i,
   fwp_cyc_if.eng cyc,
   input wire logic [fwp_pkg::DATA_W-1:0] dq_sync_i,
   output logic ce_n_o,
   output logic we_n_o,
   output logic oe_n_o,
   output logic dq_oe_o,
   output logic [fwp_pkg::ADDR_W-1:0] addr_o,
   output logic [fwp_pkg::DATA_W-1:0] dq_o
);
   logic busy, next_busy;
   logic wr, next_wr;
   logic [fwp_pkg::CNT_W-1:0] cnt, next_cnt;
   logic next_ce_n, next_we_n, next_oe_n, next_dq_oe, next_done;
   logic [fwp_pkg::ADDR_W-1:0] next_addr;
   logic [fwp_pkg::DATA_W-1:0] next_dq, next_rdata;
   localparam logic [fwp_pkg::CNT_W-1:0] WR_LAST = fwp_pkg::CNT_W'(fwp_pkg::STROBE_CYC);
   localparam logic [fwp_pkg::CNT_W-1:0] RD_LAST = fwp_pkg::CNT_W'(fwp_pkg::ACCESS_CYC + 2);

   // Strobe timing; read waits two extra cycles for the data synchroniser
   always_comb begin
      next_busy = busy;
      next_wr = wr;
      next_cnt = cnt;
      next_ce_n = ce_n_o;
      next_we_n = we_n_o;
      next_oe_n = oe_n_o;
      next_dq_oe = dq_oe_o;
      next_addr = addr_o;
      next_dq = dq_o;
      next_done = 1'b0;
      next_rdata = cyc.rdata;
      if (!busy && cyc.start) begin
         next_busy = 1'b1;
         next_wr = cyc.write;
         next_cnt = '0;
         next_addr = cyc.addr;
         next_dq = cyc.wdata;
         next_ce_n = 1'b0; // Reset pin is high here, device active
         next_we_n = !cyc.write;
         next_oe_n = cyc.write;
         next_dq_oe = cyc.write;
      end else if (busy) begin
         next_cnt = cnt + 1'b1;
         if ((wr && cnt == WR_LAST) || (!wr && cnt == RD_LAST)) begin
            next_busy = 1'b0;
            next_ce_n = 1'b1; // Release to standby between cycles
            next_we_n = 1'b1;
            next_oe_n = 1'b1;
            next_dq_oe = 1'b0;
            next_done = 1'b1;
            if (!wr) begin
               next_rdata = dq_sync_i;
            end
         end
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         busy <= 1'b0;
         wr <= 1'b0;
         cnt <= '0;
         ce_n_o <= 1'b1;
         we_n_o <= 1'b1;
         oe_n_o <= 1'b1;
         dq_oe_o <= 1'b0;
         addr_o <= '0;
         dq_o <= '0;
         cyc.done <= 1'b0;
         cyc.rdata <= '0;
      end else begin
         busy <= next_busy;
         wr <= next_wr;
         cnt <= next_cnt;
         ce_n_o <= next_ce_n;
         we_n_o <= next_we_n;
         oe_n_o <= next_oe_n;
         dq_oe_o <= next_dq_oe;
         addr_o <= next_addr;
         dq_o <= next_dq;
         cyc.done <= next_done;
         cyc.rdata <= next_rdata;
      end
   end
endmodule

/* File: src/fwp_host.sv */
`timescale 1ns/1ps
module fwp_host (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic req_i,
   input wire logic [1:0] op_i,
   input wire logic [fwp_pkg::ADDR_W-1:0] addr_i,
   input wire logic [fwp_pkg::DATA_W-1:0] wdata_i,
   input wire logic abort_i,
   input wire logic unlock_hv_i,
   output logic busy_o,
   output logic done_o,
   output logic err_o,
   output logic lock_err_o,
   output logic aborted_o,
   output logic [fwp_pkg::DATA_W-1:0] rdata_o,
   output logic ce_n_o,
   output logic we_n_o,
   output logic oe_n_o,
   output logic powerdown_reset_n_o,
   output logic hv_en_o,
   output logic [fwp_pkg::ADDR_W-1:0] addr_o,
   output logic [fwp_pkg::DATA_W-1:0] dq_o,
   output logic dq_oe_o,
   input wire logic [fwp_pkg::DATA_W-1:0] dq_i
);
   fwp_cyc_if cyc ();
   fwp_pkg::fwp_state_e state, next_state;
   logic [fwp_pkg::CNT_W-1:0] cnt, next_cnt;
   logic [1:0] step, next_step;
   logic [1:0] op, next_op;
   logic [fwp_pkg::ADDR_W-1:0] addr, next_addr;
   logic [fwp_pkg::DATA_W-1:0] wdata, next_wdata;
   logic start, next_start;
   logic cwrite, next_cwrite;
   logic [fwp_pkg::ADDR_W-1:0] caddr, next_caddr;
   logic [fwp_pkg::DATA_W-1:0] cdata, next_cdata;
   logic next_busy, next_done, next_err, next_lock_err, next_aborted;
   logic [fwp_pkg::DATA_W-1:0] next_rdata;
   logic next_rp_n, next_hv;
   logic [fwp_pkg::DATA_W-1:0] dq_meta, dq_sync;

   // Pin falls one cycle after the count starts, so count to the full width
   localparam logic [fwp_pkg::CNT_W-1:0] PULSE_LAST =
      fwp_pkg::CNT_W'(fwp_pkg::RESET_PULSE_CYC);
   localparam logic [fwp_pkg::CNT_W-1:0] RECOVER_LAST =
      fwp_pkg::CNT_W'(fwp_pkg::RESET_RECOVERY_CYC - 1);
   localparam logic [fwp_pkg::CNT_W-1:0] POLL_LAST =
      fwp_pkg::CNT_W'(fwp_pkg::POLL_LIMIT);

   assign cyc.start = start;
   assign cyc.write = cwrite;
   assign cyc.addr = caddr;
   assign cyc.wdata = cdata;

   ////////////////////////////////////////////////////////////////////////////////
   // Data pins come from another domain, two flops before use
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         dq_meta <= '0;
         dq_sync <= '0;
      end else begin
         dq_meta <= dq_i;
         dq_sync <= dq_meta;
      end
   end

   fwp_strobe u_strobe (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .cyc(cyc),
      .dq_sync_i(dq_sync),
      .ce_n_o(ce_n_o),
      .we_n_o(we_n_o),
      .oe_n_o(oe_n_o),
      .dq_oe_o(dq_oe_o),
      .addr_o(addr_o),
      .dq_o(dq_o)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Sequencer: reset pulse, recovery, command pairs, status poll
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_step = step;
      next_op = op;
      next_addr = addr;
      next_wdata = wdata;
      next_start = 1'b0;
      next_cwrite = cwrite;
      next_caddr = caddr;
      next_cdata = cdata;
      next_busy = busy_o;
      next_done = 1'b0;
      next_err = err_o;
      next_lock_err = lock_err_o;
      next_aborted = aborted_o;
      next_rdata = rdata_o;
      next_rp_n = powerdown_reset_n_o;
      next_hv = hv_en_o;
      case (state)
         fwp_pkg::FWP_RESET_HOLD: begin
            // Hold reset pin low a full pulse width; clears device status
            next_rp_n = 1'b0;
            next_hv = 1'b0;
            next_cnt = cnt + 1'b1;
            if (cnt >= PULSE_LAST) begin
               next_rp_n = 1'b1;
               next_cnt = '0;
               next_state = fwp_pkg::FWP_RECOVER;
            end
         end
         fwp_pkg::FWP_RECOVER: begin
            // No access until recovery time passes
            next_cnt = cnt + 1'b1;
            if (cnt >= RECOVER_LAST) begin
               next_cnt = '0;
               next_busy = 1'b0;
               next_state = fwp_pkg::FWP_IDLE; // Read-array default
            end
         end
         fwp_pkg::FWP_IDLE: begin
            if (req_i) begin
               next_op = op_i;
               next_addr = addr_i;
               next_wdata = wdata_i;
               next_busy = 1'b1;
               next_err = 1'b0;
               next_lock_err = 1'b0;
               next_aborted = 1'b0;
               next_step = '0;
               // Boot lock override level set before the confirm
               next_hv = unlock_hv_i && (op_i != fwp_pkg::OP_READ);
               next_start = 1'b1;
               next_cwrite = 1'b1; // Every op opens with a command write
               next_caddr = addr_i;
               next_cdata = (op_i == fwp_pkg::OP_PROGRAM) ?
                  {8'h00, fwp_pkg::CMD_PROGRAM_SETUP} :
                  (op_i == fwp_pkg::OP_ERASE) ? {8'h00, fwp_pkg::CMD_ERASE_SETUP} :
                  {8'h00, fwp_pkg::CMD_READ_ARRAY};
               next_state = fwp_pkg::FWP_CYCLE;
            end
         end
         fwp_pkg::FWP_CYCLE: begin
            // Abort only as a cycle ends; no strobe low when the pin falls
            if (abort_i && op != fwp_pkg::OP_READ && step != 2'h0 && cyc.done) begin
               next_aborted = 1'b1;
               next_cnt = '0;
               next_state = fwp_pkg::FWP_RESET_HOLD;
            end else if (cyc.done) begin
               next_step = step + 1'b1;
               next_state = fwp_pkg::FWP_GAP;
               if (op == fwp_pkg::OP_READ && step == 2'h1) begin
                  next_rdata = cyc.rdata; // Outputs held by device
                  next_state = fwp_pkg::FWP_DONE;
               end else if (op != fwp_pkg::OP_READ && step == 2'h1) begin
                  next_cnt = '0;
                  next_state = fwp_pkg::FWP_POLL; // Pair accepted
               end
            end
         end
         fwp_pkg::FWP_GAP: begin
            // Second cycle: read the array, or the confirm/data
            next_start = 1'b1;
            next_caddr = addr;
            next_cwrite = (op != fwp_pkg::OP_READ);
            next_cdata = (op == fwp_pkg::OP_ERASE) ?
               {8'h00, fwp_pkg::CMD_ERASE_CONFIRM} : wdata;
            next_state = fwp_pkg::FWP_CYCLE;
         end
         fwp_pkg::FWP_POLL: begin
            // Chip select dropped between polls; operation continues
            // Abort only while no read is in flight
            if (abort_i && (cyc.done || (!start && step == 2'h2))) begin
               next_aborted = 1'b1;
               next_cnt = '0;
               next_state = fwp_pkg::FWP_RESET_HOLD;
            end else if (!start && !cyc.done && step == 2'h2) begin
               next_start = 1'b1;
               next_cwrite = 1'b0;
               next_step = 2'h3;
            end else if (cyc.done) begin
               next_cnt = cnt + 1'b1;
               next_step = 2'h2;
               if (cyc.rdata[fwp_pkg::SR_READY_BIT]) begin
                  // Failure bits report lockout or lock
                  next_err = cyc.rdata[fwp_pkg::SR_ERASE_ERR_BIT] ||
                             cyc.rdata[fwp_pkg::SR_PROG_ERR_BIT];
                  // Low supply bit clear means a lock refused it
                  next_lock_err = next_err && !cyc.rdata[fwp_pkg::SR_SUPPLY_LOW_BIT];
                  next_hv = 1'b0;
                  next_start = 1'b1;
                  next_cwrite = 1'b1;
                  next_cdata = {8'h00, fwp_pkg::CMD_CLEAR_STATUS};
                  next_state = fwp_pkg::FWP_CLEAR;
               end else if (cnt >= POLL_LAST) begin
                  next_err = 1'b1;
                  next_aborted = 1'b1;
                  next_cnt = '0;
                  next_state = fwp_pkg::FWP_RESET_HOLD;
               end
            end
         end
         fwp_pkg::FWP_CLEAR: begin
            if (cyc.done) begin
               next_start = 1'b1;
               next_cwrite = 1'b1;
               next_cdata = {8'h00, fwp_pkg::CMD_READ_ARRAY};
               next_state = fwp_pkg::FWP_RESTORE;
            end
         end
         fwp_pkg::FWP_RESTORE: begin
            if (cyc.done) begin
               next_state = fwp_pkg::FWP_DONE;
            end
         end
         fwp_pkg::FWP_DONE: begin
            next_busy = 1'b0;
            next_done = 1'b1;
            next_state = fwp_pkg::FWP_IDLE;
         end
         default: begin
            next_cnt = '0;
            next_state = fwp_pkg::FWP_RESET_HOLD;
         end
      endcase
      // Abort pulse finishes as a done with the aborted flag
      if (state == fwp_pkg::FWP_RECOVER && next_state == fwp_pkg::FWP_IDLE && aborted_o) begin
         next_done = 1'b1;
      end
   end

   // Poll reads the status register directly; no read-status command is ever written
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state <= fwp_pkg::FWP_RESET_HOLD; // Power-up resets the flash too
         cnt <= '0;
         step <= '0;
         op <= fwp_pkg::OP_READ;
         addr <= '0;
         wdata <= '0;
         start <= 1'b0;
         cwrite <= 1'b0;
         caddr <= '0;
         cdata <= '0;
         busy_o <= 1'b1;
         done_o <= 1'b0;
         err_o <= 1'b0;
         lock_err_o <= 1'b0;
         aborted_o <= 1'b0;
         rdata_o <= '0;
         powerdown_reset_n_o <= 1'b0;
         hv_en_o <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         step <= next_step;
         op <= next_op;
         addr <= next_addr;
         wdata <= next_wdata;
         start <= next_start;
         cwrite <= next_cwrite;
         caddr <= next_caddr;
         cdata <= next_cdata;
         busy_o <= next_busy;
         done_o <= next_done;
         err_o <= next_err;
         lock_err_o <= next_lock_err;
         aborted_o <= next_aborted;
         rdata_o <= next_rdata;
         powerdown_reset_n_o <= next_rp_n;
         hv_en_o <= next_hv;
      end
   end
endmodule

/* File: dv/fwp_host_checker.sv */
`timescale 1ns/1ps
// Pin discipline of the host controller
module fwp_host_checker (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic req_i,
   input wire logic busy_o,
   input wire logic done_o,
   input wire logic err_o,
   input wire logic lock_err_o,
   input wire logic ce_n_o,
   input wire logic we_n_o,
   input wire logic oe_n_o,
   input wire logic powerdown_reset_n_o,
   input wire logic hv_en_o,
   input wire logic dq_oe_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ////////////////////////////////////////////////////////////////////////////////
   // Writes only with chip select, held for the whole strobe
   strobe_needs_select_a: assert property (!we_n_o |-> !ce_n_o)
      else $error("write strobe without chip select");
   strobe_width_a: assert property (
      $fell(we_n_o) |-> (!we_n_o && !ce_n_o && dq_oe_o) [*3])
      else $error("write strobe too short");
   // Host must never fight the flash outputs
   bus_contention_a: assert property (!oe_n_o |-> !dq_oe_o)
      else $error("host drives data while flash outputs enabled");
   // Reset pin behaviour
   reset_pin_hold_a: assert property (
      $fell(rst_i) |-> !powerdown_reset_n_o [*4])
      else $error("reset pin released too early");
   reset_pulse_width_a: assert property (
      $fell(powerdown_reset_n_o) |-> !powerdown_reset_n_o [*5])
      else $error("reset pulse too short");
   quiet_in_reset_a: assert property (
      !powerdown_reset_n_o |-> ce_n_o && we_n_o && oe_n_o)
      else $error("strobes active while reset pin low");
   // Operation bookkeeping
   hv_only_busy_a: assert property (hv_en_o |-> busy_o)
      else $error("high voltage outside an operation");
   done_single_a: assert property (done_o |=> !done_o)
      else $error("done longer than one cycle");
   lock_err_flag_a: assert property (lock_err_o |-> err_o)
      else $error("lock error without error");
   command_first_a: assert property (
      req_i && !busy_o |=> busy_o ##[1:8] !we_n_o)
      else $error("operation did not start with a command write");
endmodule
bind fwp_host fwp_host_checker chk_u (.clk_i(clk_i), .rst_i(rst_i), .req_i(req_i),
   .busy_o(busy_o), .done_o(done_o), .err_o(err_o), .lock_err_o(lock_err_o),
   .ce_n_o(ce_n_o), .we_n_o(we_n_o), .oe_n_o(oe_n_o),
   .powerdown_reset_n_o(powerdown_reset_n_o), .hv_en_o(hv_en_o), .dq_oe_o(dq_oe_o));

/* File: dv/fwp_flash_model.sv */
`timescale 1ns/1ps
// Behavioural flash: command interface, status register, boot lock
module fwp_flash_model #(
   parameter int FAST_CYC = 20,
   parameter int SLOW_CYC = 300
) (
   input wire logic clk_i,
   input wire logic ce_n_i,
   input wire logic we_n_i,
   input wire logic oe_n_i,
   input wire logic reset_n_i,
   input wire logic hv_i,
   input wire logic supply_low_i,
   input wire logic boot_unlock_i,
   input wire logic slow_i,
   input wire logic [fwp_pkg::ADDR_W-1:0] addr_i,
   input wire logic [fwp_pkg::DATA_W-1:0] dq_i,
   output logic [fwp_pkg::DATA_W-1:0] dq_o = 16'h0
);
   logic [15:0] mem [logic [19:0]];
   logic [7:0] sr = 8'h00;
   logic stat = 1'b0; // Array mode after power-up
   logic [1:0] pend = 2'h0;
   logic wr_prev = 1'b0;
   logic [19:0] wa, ta;
   logic [15:0] wd, td;
   logic [1:0] top;
   int busy = 0;
   int rec = 0;
   int fb;
   function automatic logic [15:0] rd(input logic [19:0] a);
      return mem.exists(a) ? mem[a] : 16'hffff;
   endfunction
   ////////////////////////////////////////////////////////////////////////////////
   // Command handling; a write lands when either strobe rises
   always @(posedge clk_i) begin
      if (!reset_n_i) begin
         if (busy > 0) mem[ta] = 16'h0bad; // Aborted location is garbage
         busy = 0;
         sr = 8'h00;
         stat = 1'b0;
         pend = 2'h0;
         rec = 0;
      end else begin
         if (rec < fwp_pkg::RESET_RECOVERY_CYC) rec++;
         if (busy > 0) begin
            busy--; // Chip select high does not stop it
            if (busy == 0 && top == fwp_pkg::OP_PROGRAM) mem[ta] = rd(ta) & td;
            if (busy == 0 && top == fwp_pkg::OP_ERASE) begin
               foreach (mem[a]) if (a[19:13] == ta[19:13]) mem[a] = 16'hffff;
            end
         end
         if (wr_prev && (ce_n_i || we_n_i) && busy == 0) begin
            if (pend != 2'h0) begin
               // Decision at confirm; array only changes after both steps
               fb = (pend == fwp_pkg::OP_PROGRAM) ? 4 : 5;
               if (pend == fwp_pkg::OP_ERASE && wd[7:0] != fwp_pkg::CMD_ERASE_CONFIRM)
                  sr[5] = 1'b1;
               else if (supply_low_i) sr[fb] = 1'b1;
               else if (wa[19:13] == 7'h00 && !boot_unlock_i && !hv_i)
                  sr[fb] = 1'b1;
               else begin
                  busy = slow_i ? SLOW_CYC : FAST_CYC;
                  ta = wa;
                  td = wd;
                  top = pend;
               end
               if (supply_low_i) sr[3] = 1'b1;
               pend = 2'h0;
            end else begin
               case (wd[7:0])
                  fwp_pkg::CMD_READ_ARRAY: stat = 1'b0;
                  fwp_pkg::CMD_READ_STATUS: stat = 1'b1;
                  fwp_pkg::CMD_CLEAR_STATUS: sr = 8'h00;
                  fwp_pkg::CMD_PROGRAM_SETUP: pend = fwp_pkg::OP_PROGRAM;
                  fwp_pkg::CMD_ERASE_SETUP: pend = fwp_pkg::OP_ERASE;
                  default: ;
               endcase
               if (pend != 2'h0) stat = 1'b1;
            end
         end
      end
      if (!ce_n_i && !we_n_i) begin
         wa = addr_i;
         wd = dq_i;
      end
      wr_prev = !ce_n_i && !we_n_i;
      // Floated outputs toggle every cycle, so stale data never holds steady
      if (!ce_n_i && !oe_n_i && reset_n_i && rec >= fwp_pkg::RESET_RECOVERY_CYC) begin
         dq_o <= stat ? {8'h00, busy == 0, sr[6:0]} : rd(addr_i);
      end else dq_o <= ~dq_o;
   end
endmodule

/* File: dv/flash_write_protect_power_ctrl_test.sv */
`timescale 1ns/1ps
// Random and corner traffic through the host controller into the flash model
module flash_write_protect_power_ctrl_test;
   logic clk_i = 1'b0, rst_i = 1'b1, req_i = 1'b0, abort_i = 1'b0, unlock_hv_i = 1'b0;
   logic [1:0] op_i = 2'h0;
   logic [19:0] addr_i = 20'h0, a;
   logic [15:0] wdata_i = 16'h0, exp_d;
   logic supply_low = 1'b0, boot_unlock = 1'b1, slow = 1'b0;
   logic busy_o, done_o, err_o, lock_err_o, aborted_o, ce_n_o, we_n_o, oe_n_o;
   logic powerdown_reset_n_o, hv_en_o, dq_oe_o;
   logic [19:0] addr_o;
   logic [15:0] rdata_o, dq_o, dq_i;
   logic [15:0] exp_mem [logic [19:0]];
   logic [31:0] seed = 32'h3889;
   int num_errors = 0, checks_done = 0;
   ////////////////////////////////////////////////////////////////////////////////
   // Flash reset pin comes from the controller, which follows system reset
   fwp_host dut_u (.clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .op_i(op_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .abort_i(abort_i), .unlock_hv_i(unlock_hv_i),
      .busy_o(busy_o), .done_o(done_o), .err_o(err_o), .lock_err_o(lock_err_o),
      .aborted_o(aborted_o), .rdata_o(rdata_o), .ce_n_o(ce_n_o), .we_n_o(we_n_o),
      .oe_n_o(oe_n_o), .powerdown_reset_n_o(powerdown_reset_n_o), .hv_en_o(hv_en_o),
      .addr_o(addr_o), .dq_o(dq_o), .dq_oe_o(dq_oe_o), .dq_i(dq_i));
   fwp_flash_model flash_u (.clk_i(clk_i), .ce_n_i(ce_n_o), .we_n_i(we_n_o),
      .oe_n_i(oe_n_o), .reset_n_i(powerdown_reset_n_o), .hv_i(hv_en_o),
      .supply_low_i(supply_low), .boot_unlock_i(boot_unlock), .slow_i(slow),
      .addr_i(addr_o), .dq_i(dq_o), .dq_o(dq_i));
   // 50 MHz clock
   always #10 clk_i = ~clk_i;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One request; waits for idle, then for the done pulse, both bounded
   task automatic run_op(input logic [1:0] op, input logic [19:0] ad, input logic [15:0] d);
      int n;
      n = 0;
      // Outputs are looked at 2 ns after the edge, once they have settled
      @(posedge clk_i);
      #2;
      while (busy_o !== 1'b0 && n < 8000) begin
         @(posedge clk_i);
         #2;
         n++;
      end
      op_i = op;
      addr_i = ad;
      wdata_i = d;
      req_i = 1'b1;
      @(posedge clk_i);
      #2 req_i = 1'b0;
      while (done_o !== 1'b1 && n < 8000) begin
         @(posedge clk_i);
         #2;
         n++;
      end
      // A hung operation ends the run as a failure
      if (n >= 8000) begin
         num_errors++;
         end_of_test();
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Watchdog well beyond the expected run length
   initial begin
      #800000;
      num_errors++;
      end_of_test();
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (20) @(posedge clk_i);
      #2 rst_i = 1'b0;
      @(posedge clk_i);
      #2 check("busy after reset", 16'(busy_o), 16'h1);
      run_op(fwp_pkg::OP_READ, 20'h80000, 16'h0);
      check("power-up read", rdata_o, 16'hffff);
      // Random programs into main blocks; seed[20] stays low for this seed, so fast device only
      for (int i = 0; i < 6; i++) begin
         seed = lfsr(seed);
         a = {1'b1, seed[18:0]};
         slow = seed[20];
         exp_d = (exp_mem.exists(a) ? exp_mem[a] : 16'hffff) & seed[31:16];
         exp_mem[a] = exp_d;
         run_op(fwp_pkg::OP_PROGRAM, a, seed[31:16]);
         check("program error", 16'(err_o), 16'h0);
         run_op(fwp_pkg::OP_READ, a, 16'h0);
         check("read back", rdata_o, exp_d);
      end
      // Low supply refuses both program and erase
      supply_low = 1'b1;
      for (int k = 1; k < 3; k++) begin
         run_op(2'(k), a, 16'h0000);
         check("low supply error", {err_o, lock_err_o}, 16'h2);
         run_op(fwp_pkg::OP_READ, a, 16'h0);
         check("low supply array", rdata_o, exp_d);
      end
      supply_low = 1'b0;
      // Boot lock: boot block refused, main block still writable
      boot_unlock = 1'b0;
      run_op(fwp_pkg::OP_PROGRAM, 20'h00010, 16'h1234);
      check("boot locked", {err_o, lock_err_o}, 16'h3);
      run_op(fwp_pkg::OP_READ, 20'h00010, 16'h0);
      check("boot untouched", rdata_o, 16'hffff);
      run_op(fwp_pkg::OP_PROGRAM, 20'h90000, 16'h00ff);
      check("main while locked", 16'(err_o), 16'h0);
      // High unlock voltage overrides the lock
      unlock_hv_i = 1'b1;
      run_op(fwp_pkg::OP_PROGRAM, 20'h00010, 16'h1234);
      check("hv unlock", 16'(err_o), 16'h0);
      run_op(fwp_pkg::OP_READ, 20'h00010, 16'h0);
      check("hv data", rdata_o, 16'h1234);
      unlock_hv_i = 1'b0;
      boot_unlock = 1'b1;
      run_op(fwp_pkg::OP_ERASE, 20'h00010, 16'h0);
      check("boot erase", 16'(err_o), 16'h0);
      run_op(fwp_pkg::OP_READ, 20'h00010, 16'h0);
      check("boot erased", rdata_o, 16'hffff);
      // Abort a slow program with a reset pulse, then recover
      slow = 1'b1;
      fork
         run_op(fwp_pkg::OP_PROGRAM, 20'h90100, 16'h5555);
         begin
            repeat (60) @(posedge clk_i);
            #2 abort_i = 1'b1;
         end
      join
      #2 abort_i = 1'b0;
      check("aborted", 16'(aborted_o), 16'h1);
      slow = 1'b0;
      run_op(fwp_pkg::OP_PROGRAM, 20'h90200, 16'h0f0f);
      check("after abort", {err_o, aborted_o}, 16'h0);
      run_op(fwp_pkg::OP_READ, 20'h90200, 16'h0);
      check("after abort data", rdata_o, 16'h0f0f);
      end_of_test();
   end
endmodule
